// ===== hdl/sma_alert_mask_bank.sv
// Alert mask bank: four mask bytes that gate status groups onto the alert line.
// Assumes a protocol engine on link_clk delivers decoded mask commands, stored
// configuration arrives as one load pulse on ref_clk, and status is on ref_clk.
//
// Functional notes
// [RULE1] Sub-command 7Ch under the mask command selects the input mask byte.
// [RULE2] Sub-command 7Dh under the mask command selects the temperature mask byte.
// [RULE3] Sub-command 7Eh under the mask command selects the communication mask byte.
// [RULE4] Sub-command 7Fh under the mask command selects the other mask byte.
// [RULE5] Mask bit zero lets its condition alert; one blocks it.
// [RULE6] Host uses phase FFh only for input, temperature and communication masks.
// [RULE7] Input byte: bits 7-5 writable reset zero, bit 3 stored, rest zero.
// [RULE8] Temperature bits 7 and 6 writable, loaded from stored configuration.
// [RULE9] Temperature bits 5 to 0 always read zero.
// [RULE10] Communication bits 7,6,5,4,3,1 writable and stored; bits 2,0 read zero.
// [RULE11] Other byte read-only: bits 7-1 zero, bit 0 first-alerter mask.
// [RULE12] First-alerter mask bit is fixed at one.
// [RULE13] Masking only gates the alert; status bits remain untouched.
// [RULE14] Host writes with low byte sub-command and high byte mask value.
// [RULE15] Host reads by sending sub-command then reading one mask byte.
// [RULE16] Writes spare read-only bits; new masks act on alerts immediately.
// [RULE17] Stored masks load before any condition may raise the alert.
`timescale 1ns/1ps

module sma_alert_mask_bank (
    input logic ref_clk,
    input logic nrst,
    input logic link_clk,
    input logic link_req_valid,
    input logic link_req_write,
    input logic [7:0] link_req_cmd,
    input logic [7:0] link_req_sub,
    input logic [7:0] link_req_data,
    input logic [7:0] link_req_phase,
    output logic link_req_ready,
    output logic link_rsp_valid,
    output logic [7:0] link_rsp_data,
    output logic link_rsp_error,
    input logic nvm_load,
    input logic [7:0] nvm_input_mask,
    input logic [7:0] nvm_temp_mask,
    input logic [7:0] nvm_comm_mask,
    input logic [7:0] status_input,
    input logic [7:0] status_temp,
    input logic [7:0] status_comm,
    input logic [7:0] status_other,
    output logic masks_loaded,
    output logic [3:0] group_alert,
    output logic alert_req
);

    // ------------------------------------------------------------------
    // Link front end
    // ------------------------------------------------------------------
    sma_xfer_if xfer ();

    sma_link_port u_link (
        .link_clk(link_clk),
        .nrst(nrst),
        .link_req_valid(link_req_valid),
        .link_req_write(link_req_write),
        .link_req_cmd(link_req_cmd),
        .link_req_sub(link_req_sub),
        .link_req_data(link_req_data),
        .link_req_phase(link_req_phase),
        .link_req_ready(link_req_ready),
        .link_rsp_valid(link_rsp_valid),
        .link_rsp_data(link_rsp_data),
        .link_rsp_error(link_rsp_error),
        .xfer(xfer.link)
    );

    // ------------------------------------------------------------------
    // Request arrival in the core domain
    // ------------------------------------------------------------------
    logic [2:0] req_sync_ff;
    logic req_seen_ff;

    // The first stage feeds only the second; agreement of the later two decides.
    wire req_agree = req_sync_ff[1] == req_sync_ff[2];
    wire req_event = req_agree && (req_sync_ff[2] != req_seen_ff);

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            req_sync_ff <= 3'h0;
            req_seen_ff <= 1'b0;
        end else begin
            req_sync_ff <= {req_sync_ff[1:0], xfer.req_tgl};
            req_seen_ff <= req_agree ? req_sync_ff[2] : req_seen_ff;
        end
    end

    // ------------------------------------------------------------------
    // Load sequencing
    // ------------------------------------------------------------------
    sma_pkg::sma_state_t state_ff;
    sma_pkg::sma_state_t nxt_state;

    wire running = state_ff == sma_pkg::SMA_RUN;
    wire nvm_take = (state_ff == sma_pkg::SMA_WAIT_NVM) && nvm_load;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            sma_pkg::SMA_WAIT_NVM: begin
                if (nvm_load) begin
                    nxt_state = sma_pkg::SMA_RUN;
                end
            end
            sma_pkg::SMA_RUN: begin
                nxt_state = sma_pkg::SMA_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_ff <= sma_pkg::SMA_WAIT_NVM;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    wire cmd_ok = xfer.req_cmd == sma_pkg::ALERT_MASK_CMD;
    wire hit_input = xfer.req_sub == sma_pkg::SUB_INPUT; // [RULE1]
    wire hit_temp = xfer.req_sub == sma_pkg::SUB_TEMP; // [RULE2]
    wire hit_comm = xfer.req_sub == sma_pkg::SUB_COMM; // [RULE3]
    wire hit_other = xfer.req_sub == sma_pkg::SUB_OTHER; // [RULE4]
    wire sub_ok = hit_input || hit_temp || hit_comm || hit_other;
    wire [1:0] grp_idx = hit_temp ? sma_pkg::GRP_TEMP :
                         hit_comm ? sma_pkg::GRP_COMM :
                         hit_other ? sma_pkg::GRP_OTHER : sma_pkg::GRP_INPUT;

    // Per-phase masks do not exist; input, temperature and communication bytes answer any other phase as an error.
    wire phase_ok = hit_other || (xfer.req_phase == sma_pkg::PHASE_ALL); // [RULE6]
    wire [7:0] wr_bits = sma_pkg::WR_BITS[grp_idx];
    wire ro_write = xfer.req_write && (wr_bits == sma_pkg::READ_ZERO);
    wire req_ok = running && cmd_ok && sub_ok && phase_ok && !ro_write;

    // A write carries sub-command and mask value in one request.
    wire do_write = req_event && req_ok && xfer.req_write; // [RULE14]

    // ------------------------------------------------------------------
    // Mask storage
    // ------------------------------------------------------------------
    logic [7:0] mask_ff [sma_pkg::GROUPS];

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            for (int i = 0; i < sma_pkg::GROUPS; i++) begin
                mask_ff[i] <= sma_pkg::RST_MASK; // [RULE7]
            end
        end else if (nvm_take) begin
            mask_ff[sma_pkg::GRP_INPUT] <= nvm_input_mask & sma_pkg::NVM_INPUT; // [RULE7]
            mask_ff[sma_pkg::GRP_TEMP] <= nvm_temp_mask & sma_pkg::NVM_TEMP; // [RULE8]
            mask_ff[sma_pkg::GRP_COMM] <= nvm_comm_mask & sma_pkg::NVM_COMM; // [RULE10]
            mask_ff[sma_pkg::GRP_OTHER] <= sma_pkg::RST_MASK;
        end else if (do_write) begin
            // Only writable bits are ever stored, so read-only ones stay put.
            mask_ff[grp_idx] <= xfer.req_data & wr_bits; // [RULE16]
        end
    end

    // ------------------------------------------------------------------
    // Effective masks as read back and as applied
    // ------------------------------------------------------------------
    logic [7:0] eff_mask [sma_pkg::GROUPS];
    logic [7:0] status_grp [sma_pkg::GROUPS];
    logic [3:0] grp_hit;

    assign status_grp[sma_pkg::GRP_INPUT] = status_input;
    assign status_grp[sma_pkg::GRP_TEMP] = status_temp;
    assign status_grp[sma_pkg::GRP_COMM] = status_comm;
    assign status_grp[sma_pkg::GRP_OTHER] = status_other;

    generate
        for (genvar g = 0; g < sma_pkg::GROUPS; g++) begin : g_grp
            // Unsupported bits read zero; fixed bits read one.
            assign eff_mask[g] = mask_ff[g] | sma_pkg::FIX_BITS[g]; // [RULE9] [RULE11] [RULE12]
            // A set mask bit only removes its status bit from the alert term;
            // the status itself passes through here unchanged.
            assign grp_hit[g] = |(status_grp[g] & ~eff_mask[g]); // [RULE5] [RULE13]
        end
    endgenerate

    wire [7:0] rd_byte = eff_mask[grp_idx];

    // ------------------------------------------------------------------
    // Alert generation
    // ------------------------------------------------------------------
    logic [3:0] group_alert_ff;
    logic alert_ff;

    // Masks apply on the next edge after a write, with no other restart.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            group_alert_ff <= 4'h0;
            alert_ff <= 1'b0;
        end else begin
            group_alert_ff <= running ? grp_hit : 4'h0; // [RULE17] [RULE16]
            alert_ff <= running && (|grp_hit); // [RULE17] [RULE5]
        end
    end

    assign group_alert = group_alert_ff;
    assign alert_req = alert_ff;
    assign masks_loaded = running;

    // ------------------------------------------------------------------
    // Answer back to the link
    // ------------------------------------------------------------------
    logic rsp_tgl_ff;
    logic [7:0] rsp_data_ff;
    logic rsp_err_ff;

    // A read answers the selected byte; writes and errors answer zero.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rsp_tgl_ff <= 1'b0;
            rsp_data_ff <= sma_pkg::READ_ZERO;
            rsp_err_ff <= 1'b0;
        end else if (req_event) begin
            rsp_tgl_ff <= ~rsp_tgl_ff;
            rsp_data_ff <= (req_ok && !xfer.req_write) ? rd_byte : sma_pkg::READ_ZERO; // [RULE15]
            rsp_err_ff <= !req_ok;
        end
    end

    assign xfer.rsp_tgl = rsp_tgl_ff;
    assign xfer.rsp_data = rsp_data_ff;
    assign xfer.rsp_err = rsp_err_ff;

endmodule

// ===== hdl/sma_pkg.sv
// Shared constants and types for the alert mask bank.
// Assumes a single 8-bit alert mask command carried by a protocol engine outside.
package sma_pkg;

    // ------------------------------------------------------------------
    // Command and sub-command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] ALERT_MASK_CMD = 8'h1B;
    localparam logic [7:0] SUB_INPUT = 8'h7C;
    localparam logic [7:0] SUB_TEMP = 8'h7D;
    localparam logic [7:0] SUB_COMM = 8'h7E;
    localparam logic [7:0] SUB_OTHER = 8'h7F;
    localparam logic [7:0] PHASE_ALL = 8'hFF;

    // ------------------------------------------------------------------
    // Group indices into the mask storage
    // ------------------------------------------------------------------
    localparam int GROUPS = 4;
    localparam logic [1:0] GRP_INPUT = 2'h0;
    localparam logic [1:0] GRP_TEMP = 2'h1;
    localparam logic [1:0] GRP_COMM = 2'h2;
    localparam logic [1:0] GRP_OTHER = 2'h3;

    // ------------------------------------------------------------------
    // Field layouts: writable bits, fixed ones, bits loaded from storage
    // ------------------------------------------------------------------
    localparam logic [7:0] WR_INPUT = 8'hE8;
    localparam logic [7:0] WR_TEMP = 8'hC0;
    localparam logic [7:0] WR_COMM = 8'hFA;
    localparam logic [7:0] WR_OTHER = 8'h00;
    localparam logic [3:0][7:0] WR_BITS = {WR_OTHER, WR_COMM, WR_TEMP, WR_INPUT};
    localparam logic [7:0] FIX_OTHER = 8'h01;
    localparam logic [3:0][7:0] FIX_BITS = {FIX_OTHER, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] NVM_INPUT = 8'h08;
    localparam logic [7:0] NVM_TEMP = 8'hC0;
    localparam logic [7:0] NVM_COMM = 8'hFA;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ------------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------------
    localparam int SYNC_DEPTH = 3;

    typedef enum {SMA_WAIT_NVM, SMA_RUN} sma_state_t;

endpackage

// ===== hdl/sma_xfer_if.sv
// Request and answer crossing between the link front end and the mask core.
// Assumes the link side holds every request field steady until its answer returns.
`timescale 1ns/1ps

interface sma_xfer_if;
    logic req_tgl;
    logic req_write;
    logic [7:0] req_cmd;
    logic [7:0] req_sub;
    logic [7:0] req_data;
    logic [7:0] req_phase;
    logic rsp_tgl;
    logic [7:0] rsp_data;
    logic rsp_err;

    modport link (
        output req_tgl,
        output req_write,
        output req_cmd,
        output req_sub,
        output req_data,
        output req_phase,
        input rsp_tgl,
        input rsp_data,
        input rsp_err
    );

    modport core (
        input req_tgl,
        input req_write,
        input req_cmd,
        input req_sub,
        input req_data,
        input req_phase,
        output rsp_tgl,
        output rsp_data,
        output rsp_err
    );
endinterface

// ===== hdl/sma_link_port.sv
// Link-clock front end: takes one request at a time and returns its answer.
// Assumes link_clk runs freely and nrst is held long enough to reach this domain.
`timescale 1ns/1ps

module sma_link_port (
    input logic link_clk,
    input logic nrst,
    input logic link_req_valid,
    input logic link_req_write,
    input logic [7:0] link_req_cmd,
    input logic [7:0] link_req_sub,
    input logic [7:0] link_req_data,
    input logic [7:0] link_req_phase,
    output logic link_req_ready,
    output logic link_rsp_valid,
    output logic [7:0] link_rsp_data,
    output logic link_rsp_error,
    sma_xfer_if.link xfer
);

    // ------------------------------------------------------------------
    // Reset brought into the link domain
    // ------------------------------------------------------------------
    logic [2:0] rst_sync_ff;
    logic link_nrst_ff;
    wire rst_agree = rst_sync_ff[1] == rst_sync_ff[2];

    always_ff @(posedge link_clk) begin
        rst_sync_ff <= {rst_sync_ff[1:0], nrst};
        link_nrst_ff <= rst_agree ? rst_sync_ff[2] : link_nrst_ff;
    end

    // ------------------------------------------------------------------
    // Request capture and answer return
    // ------------------------------------------------------------------
    logic busy_ff;
    logic req_tgl_ff;
    logic req_write_ff;
    logic [7:0] req_cmd_ff;
    logic [7:0] req_sub_ff;
    logic [7:0] req_data_ff;
    logic [7:0] req_phase_ff;
    logic [2:0] rsp_sync_ff;
    logic rsp_seen_ff;
    logic rsp_valid_ff;
    logic [7:0] rsp_data_ff;
    logic rsp_err_ff;

    wire take_req = link_req_valid && link_req_ready;
    wire rsp_agree = rsp_sync_ff[1] == rsp_sync_ff[2];
    wire rsp_event = rsp_agree && (rsp_sync_ff[2] != rsp_seen_ff);

    // Fields stay frozen while busy, so the core may sample them at any time.
    always_ff @(posedge link_clk) begin
        if (!link_nrst_ff) begin
            busy_ff <= 1'b0;
            req_tgl_ff <= 1'b0;
            req_write_ff <= 1'b0;
            req_cmd_ff <= 8'h00;
            req_sub_ff <= 8'h00;
            req_data_ff <= 8'h00;
            req_phase_ff <= 8'h00;
        end else if (take_req) begin
            busy_ff <= 1'b1;
            req_tgl_ff <= ~req_tgl_ff;
            req_write_ff <= link_req_write;
            req_cmd_ff <= link_req_cmd;
            req_sub_ff <= link_req_sub;
            req_data_ff <= link_req_data;
            req_phase_ff <= link_req_phase;
        end else if (rsp_event) begin
            busy_ff <= 1'b0;
        end
    end

    always_ff @(posedge link_clk) begin
        if (!link_nrst_ff) begin
            rsp_sync_ff <= 3'h0;
            rsp_seen_ff <= 1'b0;
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= 8'h00;
            rsp_err_ff <= 1'b0;
        end else begin
            rsp_sync_ff <= {rsp_sync_ff[1:0], xfer.rsp_tgl};
            rsp_seen_ff <= rsp_agree ? rsp_sync_ff[2] : rsp_seen_ff;
            rsp_valid_ff <= rsp_event;
            if (rsp_event) begin
                rsp_data_ff <= xfer.rsp_data;
                rsp_err_ff <= xfer.rsp_err;
            end
        end
    end

    assign link_req_ready = link_nrst_ff && !busy_ff;
    assign link_rsp_valid = rsp_valid_ff;
    assign link_rsp_data = rsp_data_ff;
    assign link_rsp_error = rsp_err_ff;
    assign xfer.req_tgl = req_tgl_ff;
    assign xfer.req_write = req_write_ff;
    assign xfer.req_cmd = req_cmd_ff;
    assign xfer.req_sub = req_sub_ff;
    assign xfer.req_data = req_data_ff;
    assign xfer.req_phase = req_phase_ff;

endmodule

// ===== tb/sma_host_model.sv
// Host model on the link side: offers one mask request at a time and collects its answer.
// Assumes the link clock is driven by the bench and the block answers within 20 cycles.
`timescale 1ns/1ps

module sma_host_model (
    input wire logic link_clk,
    input wire logic link_req_ready,
    input wire logic link_rsp_valid,
    input wire logic [7:0] link_rsp_data,
    input wire logic link_rsp_error,
    output logic link_req_valid,
    output logic link_req_write,
    output logic [7:0] link_req_cmd,
    output logic [7:0] link_req_sub,
    output logic [7:0] link_req_data,
    output logic [7:0] link_req_phase
);
    initial begin
        link_req_valid = 1'b0;
        link_req_write = 1'b0;
        link_req_cmd = 8'h00;
        link_req_sub = 8'h00;
        link_req_data = 8'h00;
        link_req_phase = 8'h00;
    end

    // ------------------------------------------------------------------
    // One transfer: write carries sub and mask together, read returns one byte
    // ------------------------------------------------------------------
    task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] s,
                        input logic [7:0] p, input logic [7:0] d,
                        output logic [7:0] rd, output logic er, output bit ok);
        ok = 1'b0;
        rd = 8'h00;
        er = 1'b1;
        @(posedge link_clk);
        link_req_valid <= 1'b1;
        link_req_write <= w;
        link_req_cmd <= c;
        link_req_sub <= s;
        link_req_phase <= p;
        link_req_data <= d;
        // Ready is registered, so its mid-cycle level is what the next edge samples.
        for (int n = 0; n < 40 && !ok; n++) begin
            @(negedge link_clk);
            ok = (link_req_ready === 1'b1);
        end
        @(posedge link_clk);
        // Released fields show the inverse so a stale value never looks live.
        link_req_valid <= 1'b0;
        link_req_write <= ~w;
        link_req_cmd <= ~c;
        link_req_sub <= ~s;
        link_req_phase <= ~p;
        link_req_data <= ~d;
        if (ok) begin
            ok = 1'b0;
            for (int n = 0; n < 20 && !ok; n++) begin
                @(negedge link_clk);
                if (link_rsp_valid === 1'b1) begin
                    rd = link_rsp_data;
                    er = link_rsp_error;
                    ok = 1'b1;
                end
            end
        end
    endtask
endmodule

// ===== tb/sma_alert_mask_bank_chk.sv
// Checker for the alert mask bank, watching its top-level ports only.
// Assumes nrst is the shared synchronous reset of both clock domains.
`timescale 1ns/1ps

module sma_alert_mask_bank_chk (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic link_clk,
    input wire logic link_req_valid,
    input wire logic link_req_write,
    input wire logic [7:0] link_req_cmd,
    input wire logic [7:0] link_req_sub,
    input wire logic [7:0] link_req_phase,
    input wire logic link_req_ready,
    input wire logic link_rsp_valid,
    input wire logic [7:0] link_rsp_data,
    input wire logic link_rsp_error,
    input wire logic nvm_load,
    input wire logic [7:0] status_other,
    input wire logic masks_loaded,
    input wire logic [3:0] group_alert,
    input wire logic alert_req
);
    wire take = link_req_valid && link_req_ready;
    wire phased = (link_req_sub >= sma_pkg::SUB_INPUT) && (link_req_sub <= sma_pkg::SUB_COMM);
    wire bad_phase = take && phased && (link_req_phase != sma_pkg::PHASE_ALL);
    wire bad_cmd = take && (link_req_cmd != sma_pkg::ALERT_MASK_CMD);

    a_gated_unloaded: assert property (@(posedge ref_clk) disable iff (!nrst)
        !masks_loaded |-> (group_alert == 4'h0) && !alert_req)
        else $error("alert raised before masks loaded");
    a_load_taken: assert property (@(posedge ref_clk) disable iff (!nrst)
        (nvm_load && !masks_loaded) || masks_loaded |=> masks_loaded)
        else $error("mask load not taken or lost");
    a_alert_or: assert property (@(posedge ref_clk) disable iff (!nrst)
        alert_req == (group_alert != 4'h0))
        else $error("alert line differs from group terms");
    a_other_fixed: assert property (@(posedge ref_clk) disable iff (!nrst)
        masks_loaded && $past(masks_loaded) |-> group_alert[3] == (|$past(status_other[7:1])))
        else $error("other group alert wrong");
    a_answer_time: assert property (@(posedge link_clk) disable iff (!nrst)
        take |-> ##[5:9] link_rsp_valid)
        else $error("answer missing in window");
    a_busy_hold: assert property (@(posedge link_clk) disable iff (!nrst)
        take |=> !link_req_ready [*4] ##1 !link_rsp_valid || link_req_ready)
        else $error("ready back before answer");
    a_rsp_pulse: assert property (@(posedge link_clk) disable iff (!nrst)
        link_rsp_valid |-> link_req_ready ##1 !link_rsp_valid)
        else $error("answer not a single pulse");
    a_cmd_refused: assert property (@(posedge link_clk) disable iff (!nrst)
        bad_cmd |-> ##[5:9] link_rsp_valid && link_rsp_error && (link_rsp_data == 8'h00))
        else $error("foreign command not refused");
    a_phase_refused: assert property (@(posedge link_clk) disable iff (!nrst)
        bad_phase |-> ##[5:9] link_rsp_valid && link_rsp_error)
        else $error("bad phase not refused");
    a_ro_write: assert property (@(posedge link_clk) disable iff (!nrst)
        take && link_req_write && (link_req_sub == sma_pkg::SUB_OTHER)
        |-> ##[5:9] link_rsp_valid && link_rsp_error)
        else $error("write to read-only byte accepted");

    c_load: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(masks_loaded));
    c_alert: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(alert_req));
    c_error: cover property (@(posedge link_clk) disable iff (!nrst) link_rsp_valid && link_rsp_error);
endmodule

bind sma_alert_mask_bank sma_alert_mask_bank_chk u_chk (.*);

// ===== tb/tb_sma_alert_mask_bank.sv
// Testbench for the alert mask bank: host model on the link, status and storage on ref_clk.
// Assumes the checker is bound to the design from its own file.
`timescale 1ns/1ps

module tb_sma_alert_mask_bank;
    logic ref_clk = 1'b0;
    logic link_clk = 1'b0;
    logic nrst = 1'b0;
    logic nvm_load = 1'b0;
    logic [7:0] nvm_val = 8'hFF;
    logic [7:0] st [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
    logic link_req_valid, link_req_write, link_req_ready, link_rsp_valid, link_rsp_error;
    logic [7:0] link_req_cmd, link_req_sub, link_req_data, link_req_phase, link_rsp_data;
    logic masks_loaded, alert_req;
    logic [3:0] group_alert;
    logic [7:0] rd;
    logic er;
    bit ok;
    int err_count = 0;
    int cmp_count = 0;
    logic [7:0] subs [3] = '{sma_pkg::SUB_INPUT, sma_pkg::SUB_TEMP, sma_pkg::SUB_COMM};
    logic [7:0] wr [3] = '{sma_pkg::WR_INPUT, sma_pkg::WR_TEMP, sma_pkg::WR_COMM};

    initial forever #2 ref_clk = ~ref_clk;
    // The link clock starts off an odd offset so the two domains share no phase.
    initial begin
        #3.3;
        forever #6 link_clk = ~link_clk;
    end

    sma_host_model host (.*);

    sma_alert_mask_bank dut (.nvm_input_mask(nvm_val), .nvm_temp_mask(nvm_val),
        .nvm_comm_mask(nvm_val), .status_input(st[0]), .status_temp(st[1]),
        .status_comm(st[2]), .status_other(st[3]), .*);

    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic req(input logic w, input logic [7:0] c, input logic [7:0] s,
                       input logic [7:0] p, input logic [7:0] d);
        host.xfer(w, c, s, p, d, rd, er, ok);
        if (!ok) begin
            err_count++;
            complete_run();
        end
    endtask

    task automatic ref_wait(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic alerts(input logic [3:0] exp);
        ref_wait(3);
        check("group_alert", {4'h0, group_alert}, {4'h0, exp});
        check("alert_req", {7'h00, alert_req}, {7'h00, exp != 4'h0});
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_early();
        @(posedge ref_clk);
        st[0] <= 8'h80;
        alerts(4'h0);
        req(1'b0, sma_pkg::ALERT_MASK_CMD, sma_pkg::SUB_INPUT, sma_pkg::PHASE_ALL, 8'h00);
        check("early error", {7'h00, er}, 8'h01);
        @(posedge ref_clk);
        nvm_load <= 1'b1;
        @(posedge ref_clk);
        nvm_load <= 1'b0;
        nvm_val <= 8'h00;
        alerts(4'h1);
        @(posedge ref_clk);
        nvm_load <= 1'b1;
        @(posedge ref_clk);
        nvm_load <= 1'b0;
        $display("test early done");
    endtask

    task automatic t_layout();
        logic [7:0] exp [4] = '{8'h08, 8'hC0, 8'hFA, 8'h01};
        for (int g = 0; g < 4; g++) begin
            req(1'b0, sma_pkg::ALERT_MASK_CMD, 8'h7C + 8'(g), sma_pkg::PHASE_ALL, 8'h00);
            check("stored mask", rd, exp[g]);
            check("read error", {7'h00, er}, 8'h00);
        end
        $display("test layout done");
    endtask

    task automatic t_write();
        for (int g = 0; g < 3; g++) begin
            req(1'b1, sma_pkg::ALERT_MASK_CMD, subs[g], sma_pkg::PHASE_ALL, 8'hFF);
            check("write answer", rd | 8'(er), 8'h00);
            req(1'b0, sma_pkg::ALERT_MASK_CMD, subs[g], sma_pkg::PHASE_ALL, 8'h00);
            check("ones back", rd, wr[g]);
            req(1'b1, sma_pkg::ALERT_MASK_CMD, subs[g], sma_pkg::PHASE_ALL, 8'h00);
            req(1'b0, sma_pkg::ALERT_MASK_CMD, subs[g], sma_pkg::PHASE_ALL, 8'h00);
            check("zeros back", rd, 8'h00);
        end
        req(1'b1, sma_pkg::ALERT_MASK_CMD, sma_pkg::SUB_OTHER, sma_pkg::PHASE_ALL, 8'hFE);
        check("ro write error", {7'h00, er}, 8'h01);
        $display("test write done");
    endtask

    task automatic t_refuse();
        req(1'b0, 8'h1A, sma_pkg::SUB_INPUT, sma_pkg::PHASE_ALL, 8'h00);
        check("foreign cmd", {er, rd[6:0]}, 8'h80);
        req(1'b0, sma_pkg::ALERT_MASK_CMD, 8'h7B, sma_pkg::PHASE_ALL, 8'h00);
        check("foreign sub", {7'h00, er}, 8'h01);
        req(1'b0, sma_pkg::ALERT_MASK_CMD, sma_pkg::SUB_TEMP, 8'h00, 8'h00);
        check("bad phase", {7'h00, er}, 8'h01);
        req(1'b0, sma_pkg::ALERT_MASK_CMD, sma_pkg::SUB_OTHER, 8'h00, 8'h00);
        check("other any phase", {er, rd[6:0]}, 8'h01);
        $display("test refuse done");
    endtask

    task automatic t_alert();
        for (int g = 0; g < 3; g++) begin
            @(posedge ref_clk);
            st[g] <= wr[g];
            alerts(4'(1 << g));
            req(1'b1, sma_pkg::ALERT_MASK_CMD, subs[g], sma_pkg::PHASE_ALL, wr[g]);
            alerts(4'h0);
            @(posedge ref_clk);
            st[g] <= 8'h00;
        end
        @(posedge ref_clk);
        st[3] <= 8'h01;
        alerts(4'h0);
        @(posedge ref_clk);
        st[3] <= 8'h02;
        alerts(4'h8);
        $display("test alert done");
    endtask

    initial begin
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_early();
        t_layout();
        t_write();
        t_refuse();
        t_alert();
        complete_run();
    end
endmodule
